// *** pkg/cpu_seq_pkg.sv ***
// Purpose: shared constants for the branch, frame, context and interrupt sequencer
// Assumes: 16-bit data, 20-bit addresses, byte-addressed memory
// Notes: register offsets are byte addresses on an AXI4-Lite slave
package cpu_seq_pkg;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] ARG_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] FLAG_OFS = 8'h0C;
  localparam logic [7:0] SP_OFS = 8'h10;
  localparam logic [7:0] FB_OFS = 8'h14;
  localparam logic [7:0] PC_OFS = 8'h18;
  localparam logic [7:0] STAT_OFS = 8'h1C;
  localparam logic [7:0] IRQ_OFS = 8'h20;
  localparam logic [7:0] MEM_OFS = 8'h24;
  // -------------------------------------------------------------
  // flag bit positions
  // -------------------------------------------------------------
  localparam int C_BIT = 0;
  localparam int Z_BIT = 2;
  localparam int S_BIT = 3;
  localparam int O_BIT = 5;
  localparam int I_BIT = 6;
  localparam int IPL_LSB = 12;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [19:0] SP_RST = 20'h00800;
  localparam logic [19:0] VEC_BASE = 20'hFFFC0;
  // -------------------------------------------------------------
  // displacement ranges
  // -------------------------------------------------------------
  localparam int SHORT_MIN = -127;
  localparam int SHORT_MAX = 128;
  localparam int LONG_MIN = -126;
  localparam int LONG_MAX = 129;
  // -------------------------------------------------------------
  // commands and states
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_BRANCH = 4'h1, CMD_ENTER = 4'h2, CMD_EXIT = 4'h3,
    CMD_CTXSAVE = 4'h4, CMD_CTXLOAD = 4'h5, CMD_STRING = 4'h6, CMD_SWINT = 4'h7
  } cmd_type;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00, ST_EN_PUSH = 5'h01, ST_EN_SET = 5'h02, ST_EX_POP = 5'h03,
    ST_EX_RET = 5'h04, ST_CX_NUM = 5'h05, ST_CX_MASK = 5'h06, ST_CX_REG = 5'h07,
    ST_CX_CORR = 5'h08, ST_CX_ADJ = 5'h09, ST_STR = 5'h0A, ST_IRQ_FLG = 5'h0B,
    ST_IRQ_PC = 5'h0C, ST_IRQ_SET = 5'h0D
  } state_type;
endpackage : cpu_seq_pkg

// *** rtl/cpu_branch_frame_context_irq.sv ***
// Purpose: sequencer for conditional branches, stack frames, task context and interrupts
// Assumes: software steers it through AXI4-Lite; a word memory models stack and tables
// Notes: one memory access per cycle; one operation at a time
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] signed conditions use zero, sign and overflow as for signed compares
// [RULE2] remaining conditions test carry, zero, sign or overflow singly or combined
// [RULE3] carry, zero and sign conditions accept displacements -127 to +128
// [RULE4] signed and overflow conditions accept displacements -126 to +129
// [RULE5] frame build takes one unsigned byte giving local area size
// [RULE6] frame build pushes frame base, copies stack pointer, subtracts size
// [RULE7] teardown copies frame base to stack pointer, pops it, then returns
// [RULE8] context ops take task number address and table start, software prepares
// [RULE9] entry address is twice task number plus table start; mask byte there
// [RULE10] context save pushes every register selected by the mask
// [RULE11] byte after the mask is the stack pointer correction
// [RULE12] context save ends by subtracting the correction from the stack pointer
// [RULE13] context restore reloads registers without moving the stack pointer
// [RULE14] context restore ends by adding the correction to the stack pointer
// [RULE15] special interrupts unmaskable; peripheral ones gated by enable and levels
// [RULE16] software interrupts come from four instruction causes; here one request bit, irq_q[7], set by CMD_SWINT
// [RULE17] normal instructions finish before interrupts are resolved
// [RULE18] string and sum-of-products operations are suspended for interrupts; here only the string op exists
// [RULE19] interrupt pushes flags and pc, then updates flags and priority level
// [RULE20] during the interrupt sequence only reset is accepted
// [RULE21] taken branch jumps to target, else falls to next instruction
// [RULE22] carry conditions: carry set; carry set and zero clear; zero set
// [RULE23] stack grows down; push pre-decrements, pop post-increments
module cpu_branch_frame_context_irq #(
  parameter int MEM_WORDS = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  initial begin
    if (MEM_WORDS < 16 || MEM_WORDS > 65536) $error("MEM_WORDS out of range");
  end
  localparam int AW = $clog2(MEM_WORDS);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  cpu_seq_pkg::state_type state_q;
  logic [15:0] mem [MEM_WORDS];
  logic [15:0] flag_q, arg_q;
  logic [19:0] addr_q, sp_q, fb_q, pc_q, ent_q;
  logic [7:0] mask_q, corr_q;
  logic [2:0] idx_q;
  logic [15:0] regs_q [8];
  logic save_q, busy_q, range_err_q, taken_q;
  logic [7:0] irq_q;
  logic [5:0] specReq;
  logic periphReq, swReq, anyIrq, accept;
  logic [7:0] awAddr_q, arAddr_q;
  logic awHave_q, wHave_q;
  logic [31:0] wData_q;
  logic memWr;
  logic [AW-1:0] memWA;
  logic [15:0] memWD;

  function automatic logic cond_true(input logic [3:0] cc, input logic [15:0] f);
    logic c, z, s, o;
    c = f[cpu_seq_pkg::C_BIT];
    z = f[cpu_seq_pkg::Z_BIT];
    s = f[cpu_seq_pkg::S_BIT];
    o = f[cpu_seq_pkg::O_BIT];
    case (cc)
      4'h0: cond_true = c; // RULE22
      4'h1: cond_true = c & ~z; // RULE22
      4'h2: cond_true = z; // RULE22
      4'h3: cond_true = s; // RULE2
      4'h4: cond_true = ~c; // RULE2
      4'h5: cond_true = ~c | z; // RULE2
      4'h6: cond_true = ~z; // RULE2
      4'h7: cond_true = ~s; // RULE2
      4'h8: cond_true = z | (s ^ o); // RULE1
      4'h9: cond_true = o; // RULE2
      4'hA: cond_true = ~(s ^ o); // RULE1
      4'hB: cond_true = ~(s ^ o) & ~z; // RULE1
      4'hC: cond_true = ~o; // RULE2
      4'hD: cond_true = s ^ o; // RULE1
      default: cond_true = 1'b0;
    endcase
  endfunction : cond_true

  // signed and overflow conditions use the longer-offset range
  function automatic logic disp_ok(input logic [3:0] cc, input logic [15:0] d);
    int v;
    v = $signed(d);
    if (cc >= 4'h8) disp_ok = v >= cpu_seq_pkg::LONG_MIN && v <= cpu_seq_pkg::LONG_MAX; // RULE4
    else disp_ok = v >= cpu_seq_pkg::SHORT_MIN && v <= cpu_seq_pkg::SHORT_MAX; // RULE3
  endfunction : disp_ok

  function automatic logic [AW-1:0] widx(input logic [19:0] a);
    widx = a[AW:1];
  endfunction : widx

  // -------------------------------------------------------------
  // interrupt gating
  // -------------------------------------------------------------
  // irq_q: [5:0] special sources, [6] peripheral request, level in arg[14:12]
  assign specReq = irq_q[5:0]; // RULE15
  assign periphReq = irq_q[6] & flag_q[cpu_seq_pkg::I_BIT]
    & (arg_q[14:12] > flag_q[cpu_seq_pkg::IPL_LSB+:3]); // RULE15
  assign swReq = irq_q[7]; // RULE16
  assign anyIrq = (|specReq) | periphReq | swReq;
  // normal ops end before sampling; string op checks each step
  assign accept = anyIrq && (state_q == cpu_seq_pkg::ST_IDLE
    || state_q == cpu_seq_pkg::ST_STR); // RULE17 RULE18 RULE20

  // -------------------------------------------------------------
  // AXI4-Lite write path
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      if (awHave_q && wHave_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = !wHave_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  wire wrFire = awHave_q && wHave_q && !s_axi_bvalid;

  // -------------------------------------------------------------
  // AXI4-Lite read path
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == cpu_seq_pkg::FLAG_OFS) s_axi_rdata <= {16'h0000, flag_q};
      else if (s_axi_araddr == cpu_seq_pkg::ARG_OFS) s_axi_rdata <= {16'h0000, arg_q};
      else if (s_axi_araddr == cpu_seq_pkg::ADDR_OFS) s_axi_rdata <= {12'h000, addr_q};
      else if (s_axi_araddr == cpu_seq_pkg::SP_OFS) s_axi_rdata <= {12'h000, sp_q};
      else if (s_axi_araddr == cpu_seq_pkg::FB_OFS) s_axi_rdata <= {12'h000, fb_q};
      else if (s_axi_araddr == cpu_seq_pkg::PC_OFS) s_axi_rdata <= {12'h000, pc_q};
      else if (s_axi_araddr == cpu_seq_pkg::STAT_OFS)
        s_axi_rdata <= {24'h000000, 3'b000, state_q != cpu_seq_pkg::ST_IDLE, 1'b0, range_err_q, taken_q, busy_q};
      else if (s_axi_araddr == cpu_seq_pkg::IRQ_OFS) s_axi_rdata <= {24'h000000, irq_q};
      else if (s_axi_araddr == cpu_seq_pkg::MEM_OFS)
        s_axi_rdata <= {16'h0000, mem[widx(addr_q)]};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10; // unmapped answers SLVERR
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // -------------------------------------------------------------
  // memory: software writes only while idle, sequencer otherwise
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (memWr) mem[memWA] <= memWD;
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  always_comb begin
    memWr = 1'b0;
    memWA = widx(sp_q - 20'h2);
    memWD = fb_q[15:0];
    case (state_q)
      cpu_seq_pkg::ST_IDLE: begin
        memWr = wrFire && awAddr_q == cpu_seq_pkg::MEM_OFS;
        memWA = widx(addr_q);
        memWD = wData_q[15:0];
      end
      cpu_seq_pkg::ST_EN_PUSH: memWr = 1'b1; // RULE6 RULE23
      cpu_seq_pkg::ST_CX_REG: begin
        memWr = save_q && mask_q[idx_q]; // RULE10
        memWA = widx(ent_q - 20'h2);
        memWD = regs_q[idx_q];
      end
      cpu_seq_pkg::ST_IRQ_FLG: begin
        memWr = 1'b1; // RULE19
        memWD = flag_q;
      end
      cpu_seq_pkg::ST_IRQ_PC: begin
        memWr = 1'b1; // RULE19
        memWD = pc_q[15:0];
      end
      default: memWr = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cpu_seq_pkg::ST_IDLE;
      flag_q <= cpu_seq_pkg::FLAG_RST;
      sp_q <= cpu_seq_pkg::SP_RST;
      fb_q <= 20'h00000;
      pc_q <= 20'h00000;
      arg_q <= 16'h0000;
      addr_q <= 20'h00000;
      ent_q <= 20'h00000;
      mask_q <= 8'h00;
      corr_q <= 8'h00;
      idx_q <= 3'h0;
      save_q <= 1'b0;
      busy_q <= 1'b0;
      range_err_q <= 1'b0;
      taken_q <= 1'b0;
      irq_q <= 8'h00;
      for (int i = 0; i < 8; i++) regs_q[i] <= 16'h0000;
    end else begin
      if (wrFire && state_q == cpu_seq_pkg::ST_IDLE) begin
        if (awAddr_q == cpu_seq_pkg::ARG_OFS) arg_q <= wData_q[15:0];
        else if (awAddr_q == cpu_seq_pkg::ADDR_OFS) addr_q <= wData_q[19:0];
        else if (awAddr_q == cpu_seq_pkg::FLAG_OFS) flag_q <= wData_q[15:0];
        else if (awAddr_q == cpu_seq_pkg::SP_OFS) sp_q <= wData_q[19:0];
        else if (awAddr_q == cpu_seq_pkg::FB_OFS) fb_q <= wData_q[19:0];
        else if (awAddr_q == cpu_seq_pkg::PC_OFS) pc_q <= wData_q[19:0];
      end
      // request bits: new set wins over the clear in ST_IRQ_SET
      if (wrFire && awAddr_q == cpu_seq_pkg::IRQ_OFS) irq_q <= irq_q | wData_q[7:0];
      case (state_q)
        cpu_seq_pkg::ST_IDLE: begin
          busy_q <= 1'b0;
          if (accept) begin
            state_q <= cpu_seq_pkg::ST_IRQ_FLG; // RULE17
            busy_q <= 1'b1;
          end else if (wrFire && awAddr_q == cpu_seq_pkg::CMD_OFS) begin
            busy_q <= 1'b1;
            case (wData_q[3:0])
              cpu_seq_pkg::CMD_BRANCH: begin
                range_err_q <= !disp_ok(wData_q[7:4], arg_q);
                taken_q <= cond_true(wData_q[7:4], flag_q) && disp_ok(wData_q[7:4], arg_q);
                if (cond_true(wData_q[7:4], flag_q) && disp_ok(wData_q[7:4], arg_q))
                  pc_q <= pc_q + {{4{arg_q[15]}}, arg_q}; // RULE21
                else
                  pc_q <= pc_q + 20'h2; // RULE21
              end
              cpu_seq_pkg::CMD_ENTER: state_q <= cpu_seq_pkg::ST_EN_PUSH;
              cpu_seq_pkg::CMD_EXIT: begin
                sp_q <= fb_q; // RULE7
                state_q <= cpu_seq_pkg::ST_EX_POP;
              end
              cpu_seq_pkg::CMD_CTXSAVE, cpu_seq_pkg::CMD_CTXLOAD: begin
                save_q <= wData_q[3:0] == cpu_seq_pkg::CMD_CTXSAVE;
                state_q <= cpu_seq_pkg::ST_CX_NUM; // RULE8
              end
              cpu_seq_pkg::CMD_STRING: state_q <= cpu_seq_pkg::ST_STR;
              cpu_seq_pkg::CMD_SWINT: irq_q[7] <= 1'b1; // RULE16
              default: busy_q <= 1'b0;
            endcase
          end
        end
        cpu_seq_pkg::ST_EN_PUSH: begin
          sp_q <= sp_q - 20'h2; // RULE6 RULE23
          state_q <= cpu_seq_pkg::ST_EN_SET;
        end
        cpu_seq_pkg::ST_EN_SET: begin
          fb_q <= sp_q; // RULE6
          sp_q <= sp_q - {12'h000, arg_q[7:0]}; // RULE5 RULE6
          state_q <= cpu_seq_pkg::ST_IDLE;
        end
        cpu_seq_pkg::ST_EX_POP: begin
          fb_q <= {4'h0, mem[widx(sp_q)]}; // RULE7 RULE23
          sp_q <= sp_q + 20'h2;
          state_q <= cpu_seq_pkg::ST_EX_RET;
        end
        cpu_seq_pkg::ST_EX_RET: begin
          pc_q <= {4'h0, mem[widx(sp_q)]}; // RULE7
          sp_q <= sp_q + 20'h2;
          state_q <= cpu_seq_pkg::ST_IDLE;
        end
        cpu_seq_pkg::ST_CX_NUM: begin
          // task number byte sits at arg; table start in addr
          ent_q <= addr_q + {11'h000, mem[widx({4'h0, arg_q})][7:0], 1'b0}; // RULE9
          state_q <= cpu_seq_pkg::ST_CX_MASK;
        end
        cpu_seq_pkg::ST_CX_MASK: begin
          mask_q <= mem[widx(ent_q)][7:0]; // RULE9
          corr_q <= mem[widx(ent_q)][15:8]; // RULE11
          idx_q <= save_q ? 3'h7 : 3'h0;
          ent_q <= sp_q; // walk pointer: sp moves only by the correction
          state_q <= cpu_seq_pkg::ST_CX_REG;
        end
        cpu_seq_pkg::ST_CX_REG: begin
          if (save_q) begin
            if (mask_q[idx_q]) ent_q <= ent_q - 20'h2; // RULE10 RULE23
            if (idx_q == 3'h0) state_q <= cpu_seq_pkg::ST_CX_CORR;
            else idx_q <= idx_q - 3'h1;
          end else begin
            if (mask_q[idx_q]) begin
              regs_q[idx_q] <= mem[widx(ent_q)]; // RULE13
              ent_q <= ent_q + 20'h2;
            end
            if (idx_q == 3'h7) state_q <= cpu_seq_pkg::ST_CX_CORR;
            else idx_q <= idx_q + 3'h1;
          end
        end
        cpu_seq_pkg::ST_CX_CORR: state_q <= cpu_seq_pkg::ST_CX_ADJ;
        cpu_seq_pkg::ST_CX_ADJ: begin
          if (save_q) sp_q <= sp_q - {12'h000, corr_q}; // RULE12
          else sp_q <= sp_q + {12'h000, corr_q}; // RULE14
          state_q <= cpu_seq_pkg::ST_IDLE;
        end
        cpu_seq_pkg::ST_STR: begin
          // one element per cycle, count in arg; interrupt may cut in between
          if (accept) state_q <= cpu_seq_pkg::ST_IRQ_FLG; // RULE18
          else if (arg_q == 16'h0000) state_q <= cpu_seq_pkg::ST_IDLE;
          else arg_q <= arg_q - 16'h1;
        end
        cpu_seq_pkg::ST_IRQ_FLG: begin
          sp_q <= sp_q - 20'h2; // RULE19 RULE23
          state_q <= cpu_seq_pkg::ST_IRQ_PC;
        end
        cpu_seq_pkg::ST_IRQ_PC: begin
          sp_q <= sp_q - 20'h2; // RULE19
          state_q <= cpu_seq_pkg::ST_IRQ_SET;
        end
        cpu_seq_pkg::ST_IRQ_SET: begin
          flag_q[cpu_seq_pkg::I_BIT] <= 1'b0; // RULE19
          if (!(|specReq) && !swReq) flag_q[cpu_seq_pkg::IPL_LSB+:3] <= arg_q[14:12];
          pc_q <= cpu_seq_pkg::VEC_BASE;
          irq_q <= (wrFire && awAddr_q == cpu_seq_pkg::IRQ_OFS) ? wData_q[7:0] : 8'h00;
          state_q <= cpu_seq_pkg::ST_IDLE;
        end
        default: state_q <= cpu_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_irq_tail;
    state_q == cpu_seq_pkg::ST_IRQ_PC ##1 state_q == cpu_seq_pkg::ST_IRQ_SET;
  endsequence
  property p_irq_seq;
    state_q == cpu_seq_pkg::ST_IRQ_FLG |=> s_irq_tail;
  endproperty
  a_irq_seq: assert property (p_irq_seq) else $error("interrupt sequence broken"); // RULE19
  property p_enter_sp;
    state_q == cpu_seq_pkg::ST_EN_SET |=> sp_q == $past(sp_q) - {12'h000, $past(arg_q[7:0])};
  endproperty
  a_enter_sp: assert property (p_enter_sp) else $error("frame build sp wrong"); // RULE6
  property p_enter_fb;
    state_q == cpu_seq_pkg::ST_EN_SET |=> fb_q == $past(sp_q);
  endproperty
  a_enter_fb: assert property (p_enter_fb) else $error("frame base not copied"); // RULE6
  property p_walk_sp;
    state_q == cpu_seq_pkg::ST_CX_REG |=> sp_q == $past(sp_q);
  endproperty
  a_walk_sp: assert property (p_walk_sp) else $error("sp moved in walk"); // RULE13
  property p_save_adj;
    state_q == cpu_seq_pkg::ST_CX_ADJ && save_q |=> sp_q == $past(sp_q) - {12'h000, corr_q};
  endproperty
  a_save_adj: assert property (p_save_adj) else $error("save adjust wrong"); // RULE12
  property p_irq_take;
    state_q == cpu_seq_pkg::ST_IDLE && accept |=> state_q == cpu_seq_pkg::ST_IRQ_FLG;
  endproperty
  a_irq_take: assert property (p_irq_take) else $error("request not taken"); // RULE17
endmodule : cpu_branch_frame_context_irq

// *** bench/axi_host.sv ***
// Purpose: AXI4-Lite master model for the sequencer register port
// Assumes: one transfer at a time; readies are sampled mid-cycle for the coming edge
// Notes: a wait that runs out ends the run through the bench verdict
`timescale 1ns/1ns
module axi_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // -------------------------------------------------------------
  // idle levels at time zero
  // -------------------------------------------------------------
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // -------------------------------------------------------------
  // transfers
  // -------------------------------------------------------------
  // hung waits are cut here so the run always reaches the verdict
  task automatic hang();
    $display("wrong value bus wait expected handshake seen none");
    testbench.fail_count++;
    testbench.give_verdict();
  endtask : hang
  // address and data offered together, each released once taken
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      n++;
      if (n > 200) hang();
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask : write_reg
  // data and response taken at the edge where rvalid is seen
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rready && rvalid;
      d = rdata;
      r = rresp;
      n++;
      if (n > 200) hang();
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask : read_reg
endmodule : axi_host

// *** bench/testbench.sv ***
// Purpose: self-checking bench for branch, frame, context and interrupt sequencing
// Assumes: registers reached through the host model only
// Notes: branch checks use the taken status bit, since target bases are design choices
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic rst_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] v;
  logic [1:0] r;
  int fail_count = 0;
  int compares = 0;
  // -------------------------------------------------------------
  // clock, design and host
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cpu_branch_frame_context_irq i_cpu_branch_frame_context_irq (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  axi_host i_axi_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_axi_host.write_reg(a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_axi_host.read_reg(a, v, r);
  endtask : rd
  // start a command, then poll busy under a bound
  task automatic run(input logic [3:0] cmd, input logic [3:0] cnd);
    int n;
    wr(cpu_seq_pkg::CMD_OFS, {24'h0, cnd, cmd});
    n = 0;
    do begin
      rd(cpu_seq_pkg::STAT_OFS);
      n++;
      if (n > 100) i_axi_host.hang();
    end while (v[0] !== 1'b0);
  endtask : run
  // expected outcome of each condition code from C, Z, S, O
  function automatic logic cond_ok(input int c, input logic [3:0] f);
    logic cf, zf, sf, of;
    {of, sf, zf, cf} = f;
    case (c)
      0: return cf;
      1: return cf && !zf;
      2: return zf;
      3: return sf;
      4: return !cf;
      5: return !cf || zf;
      6: return !zf;
      7: return !sf;
      8: return zf || (sf != of);
      9: return of;
      10: return sf == of;
      11: return (sf == of) && !zf;
      12: return !of;
      default: return sf != of;
    endcase
  endfunction : cond_ok
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [15:0] fl;
    int disp [4];
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(cpu_seq_pkg::SP_OFS);
    check("sp reset", {12'h0, cpu_seq_pkg::SP_RST}, v);
    rd(cpu_seq_pkg::FLAG_OFS);
    check("flag reset", {16'h0, cpu_seq_pkg::FLAG_RST}, v);
    rd(8'h40);
    check("unmapped resp", 32'h2, {30'h0, r});
    check("unmapped data", 32'h0, v);
    // condition codes 0 to 13 against every flag pattern
    for (int f = 0; f < 16; f++) begin
      fl = 16'h0000;
      fl[cpu_seq_pkg::C_BIT] = f[0];
      fl[cpu_seq_pkg::Z_BIT] = f[1];
      fl[cpu_seq_pkg::S_BIT] = f[2];
      fl[cpu_seq_pkg::O_BIT] = f[3];
      for (int c = 0; c < 14; c++) begin
        wr(cpu_seq_pkg::FLAG_OFS, {16'h0, fl});
        wr(cpu_seq_pkg::ARG_OFS, 32'h10);
        run(4'h1, c[3:0]);
        check("branch taken", {31'h0, cond_ok(c, f[3:0])}, {31'h0, v[1]});
      end
    end
    // range edges: carry-based code 0 and signed code 8, both true with C and Z set
    for (int k = 0; k < 2; k++) begin
      disp = k ? '{129, 130, -126, -127} : '{128, 129, -127, -128};
      for (int j = 0; j < 4; j++) begin
        wr(cpu_seq_pkg::FLAG_OFS, 32'h5);
        wr(cpu_seq_pkg::ARG_OFS, {16'h0, 16'(disp[j])});
        run(4'h1, k ? 4'h8 : 4'h0);
        check("range error", {31'h0, j[0]}, {31'h0, v[2]});
        check("range taken", {31'h0, !j[0]}, {31'h0, v[1]});
      end
    end
    // frame build then teardown
    wr(cpu_seq_pkg::SP_OFS, 32'h400);
    wr(cpu_seq_pkg::FB_OFS, 32'h1234);
    wr(cpu_seq_pkg::ARG_OFS, 32'h3);
    run(4'h2, 4'h0);
    rd(cpu_seq_pkg::FB_OFS);
    check("fb after build", 32'h3FE, v);
    rd(cpu_seq_pkg::SP_OFS);
    check("sp after build", 32'h3FB, v);
    wr(cpu_seq_pkg::ADDR_OFS, 32'h3FE);
    rd(cpu_seq_pkg::MEM_OFS);
    check("pushed fb", 32'h1234, v & 32'hFFFF);
    run(4'h3, 4'h0);
    rd(cpu_seq_pkg::FB_OFS);
    check("fb after teardown", 32'h1234, v);
    // task 3 at 0x100, table at 0x200, entry mask 0x07 correction 0x06
    wr(cpu_seq_pkg::ADDR_OFS, 32'h100);
    wr(cpu_seq_pkg::MEM_OFS, 32'h3);
    wr(cpu_seq_pkg::ADDR_OFS, 32'h206);
    wr(cpu_seq_pkg::MEM_OFS, 32'h0607);
    wr(cpu_seq_pkg::SP_OFS, 32'h500);
    wr(cpu_seq_pkg::ARG_OFS, 32'h100);
    wr(cpu_seq_pkg::ADDR_OFS, 32'h200);
    run(4'h4, 4'h0);
    rd(cpu_seq_pkg::SP_OFS);
    check("sp after save", 32'h4FA, v);
    run(4'h5, 4'h0);
    rd(cpu_seq_pkg::SP_OFS);
    check("sp after restore", 32'h500, v);
    // software interrupt clears the enable and stacks state
    wr(cpu_seq_pkg::FLAG_OFS, 32'h40);
    wr(cpu_seq_pkg::SP_OFS, 32'h600);
    run(4'h7, 4'h0);
    rd(cpu_seq_pkg::FLAG_OFS);
    check("flag i after swint", 32'h0, {31'h0, v[cpu_seq_pkg::I_BIT]});
    rd(cpu_seq_pkg::SP_OFS);
    check("sp moved by swint", 32'h1, {31'h0, v < 32'h600});
    // peripheral masked with enable clear, special taken regardless
    wr(cpu_seq_pkg::FLAG_OFS, 32'h0);
    wr(cpu_seq_pkg::PC_OFS, 32'h1000);
    wr(cpu_seq_pkg::IRQ_OFS, 32'h40);
    run(4'h0, 4'h0);
    rd(cpu_seq_pkg::PC_OFS);
    check("pc masked irq", 32'h1000, v);
    wr(cpu_seq_pkg::IRQ_OFS, 32'h1);
    run(4'h0, 4'h0);
    rd(cpu_seq_pkg::PC_OFS);
    check("pc special irq", 32'h1, {31'h0, v !== 32'h1000});
    // string run on the 0x100 count left in arg, cut by a special request
    wr(cpu_seq_pkg::CMD_OFS, 32'h6);
    wr(cpu_seq_pkg::IRQ_OFS, 32'h1);
    run(4'h0, 4'h0);
    rd(cpu_seq_pkg::ARG_OFS);
    check("string count left", 32'h1, {31'h0, v != 32'h0 && v < 32'h100});
    give_verdict();
  end
endmodule : testbench
